// File: logic/tgbpd_top.sv
// Touch group blocking, pattern detection and base range report
module tgbpd_top
   import tgbpd_pkg::*;
#(
   parameter int N = NUM_INPUTS
) (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire logic                      cycle_done,
   input  wire tgbpd_pkg::tgbpd_sense_t   sense,
   input  wire tgbpd_pkg::tgbpd_reg_req_t reg_req,
   input  wire logic                      int_clear,
   output logic      [7:0]                reg_rdata,
   output logic      [1:0]                pattern_threshold_select,
   output logic      [N-1:0]              touch_report,
   output tgbpd_pkg::tgbpd_status_t       status,
   output logic                           alert_n
);
   import tgbpd_pkg::*;

   initial begin
      if (N != NUM_INPUTS) $error("tgbpd_top: only three inputs supported");
   end

   typedef struct packed {
      logic [7:0]   group_cfg;
      logic [7:0]   pattern_cfg;
      logic [7:0]   pattern_sel;
      logic [N-1:0] base_fault;
      logic [N-1:0] valid;
      logic [N-1:0] report;
      logic         excess;
      logic         event_flag;
      logic         cond;
      logic [7:0]   rdata;
   } tgbpd_state_t;

   tgbpd_state_t st_ff, nxt_st;
   logic [1:0]   rst_sync_ff;
   logic         rst_n_s;
   logic [N-1:0] chosen;
   logic [N-1:0] touched;
   logic [N-1:0] qualify;
   logic [1:0]   qual_cnt;
   logic [1:0]   sel_cnt;
   logic         match;
   logic         group_block_enable;
   logic [1:0]   simultaneous_touch_limit;
   logic [1:0]   limit_n;
   logic         pattern_detect_enable;
   logic         pattern_compare_mode;
   logic         pattern_alert_enable;
   logic         valid_released;

   // Reset release through two flops
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n_s = rst_sync_ff[1];

   assign group_block_enable       = st_ff.group_cfg[POS_BLOCK_EN];
   assign simultaneous_touch_limit = st_ff.group_cfg[POS_LIMIT_LO +: 2];
   assign pattern_detect_enable    = st_ff.pattern_cfg[POS_PAT_EN];
   assign pattern_threshold_select = st_ff.pattern_cfg[POS_PAT_TH_LO +: 2];
   assign pattern_compare_mode     = st_ff.pattern_cfg[POS_PAT_MODE];
   assign pattern_alert_enable     = st_ff.pattern_cfg[POS_PAT_ALERT];

   assign limit_n = (simultaneous_touch_limit == 2'h0) ? 2'h1 :
                    (simultaneous_touch_limit == 2'h1) ? 2'h2 : 2'h3;

   assign touched = sense.over_touch;

   tgbpd_select #(
      .N (N)
   ) u_select (
      .touched (touched),
      .limit   (limit_n),
      .chosen  (chosen)
   );

   assign qualify = sense.over_pattern | sense.noise;
   assign qual_cnt = 2'({1'b0, qualify[0]} + {1'b0, qualify[1]} + {1'b0, qualify[2]});
   assign sel_cnt  = 2'({1'b0, st_ff.pattern_sel[0]} + {1'b0, st_ff.pattern_sel[1]}
                        + {1'b0, st_ff.pattern_sel[2]});
   assign match = pattern_compare_mode
                ? ((qualify & st_ff.pattern_sel[N-1:0]) == st_ff.pattern_sel[N-1:0])
                : (qual_cnt >= sel_cnt);

   assign valid_released = |(st_ff.valid & ~touched);

   always_comb begin
      nxt_st          = st_ff;
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            ADDR_GROUP_CFG:   nxt_st.group_cfg   = reg_req.wdata & MASK_GROUP_CFG;
            ADDR_PATTERN_CFG: nxt_st.pattern_cfg = reg_req.wdata & MASK_PATTERN_CFG;
            ADDR_PATTERN_SEL: nxt_st.pattern_sel = reg_req.wdata & MASK_PATTERN_SEL;
            default:          nxt_st.rdata       = st_ff.rdata;
         endcase
      end
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_GROUP_CFG:   nxt_st.rdata = st_ff.group_cfg;
            ADDR_PATTERN_CFG: nxt_st.rdata = st_ff.pattern_cfg;
            ADDR_PATTERN_SEL: nxt_st.rdata = st_ff.pattern_sel;
            ADDR_BASE_RANGE:  nxt_st.rdata = {5'h00, st_ff.base_fault};
            default:          nxt_st.rdata = 8'h00;
         endcase
      end
      // Host clear takes effect only after the condition is gone
      if (int_clear && !st_ff.cond) begin
         nxt_st.event_flag = 1'b0;
      end
      if (cycle_done) begin
         nxt_st.base_fault = sense.base_fault;
         nxt_st.cond       = pattern_detect_enable && match;
         if (pattern_detect_enable && match) begin
            nxt_st.event_flag = 1'b1;
         end
         if (pattern_detect_enable && match) begin
            nxt_st.report = '0;
         end else if (!group_block_enable) begin
            nxt_st.report = touched;
            nxt_st.valid  = '0;
         end else begin
            // Keep the valid set until one of its pads releases
            if (st_ff.valid == '0 || valid_released) begin
               nxt_st.valid = chosen;
            end else begin
               nxt_st.valid = st_ff.valid & touched;
            end
            nxt_st.report = nxt_st.valid;
         end
         if (group_block_enable && (touched & ~nxt_st.valid) != '0) begin
            nxt_st.excess = 1'b1;
         end else begin
            nxt_st.excess = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n_s) begin
      if (!rst_n_s) begin
         st_ff.group_cfg   <= RST_GROUP_CFG;
         st_ff.pattern_cfg <= RST_PATTERN_CFG;
         st_ff.pattern_sel <= RST_PATTERN_SEL;
         st_ff.base_fault  <= '0;
         st_ff.valid       <= '0;
         st_ff.report      <= '0;
         st_ff.excess      <= 1'b0;
         st_ff.event_flag  <= 1'b0;
         st_ff.cond        <= 1'b0;
         st_ff.rdata       <= 8'h00;
      end else begin
         st_ff.group_cfg   <= nxt_st.group_cfg;
         st_ff.pattern_cfg <= nxt_st.pattern_cfg;
         st_ff.pattern_sel <= nxt_st.pattern_sel;
         st_ff.base_fault  <= nxt_st.base_fault;
         st_ff.valid       <= nxt_st.valid;
         st_ff.report      <= nxt_st.report;
         st_ff.excess      <= nxt_st.excess;
         st_ff.event_flag  <= nxt_st.event_flag;
         st_ff.cond        <= nxt_st.cond;
         st_ff.rdata       <= nxt_st.rdata;
      end
   end

   assign reg_rdata                      = st_ff.rdata;
   assign touch_report                   = st_ff.report;
   assign status.excess_touch_flag       = st_ff.excess;
   assign status.pattern_event_flag      = st_ff.event_flag;
   assign status.base_range_summary_flag = |st_ff.base_fault;
   assign status.pattern_alert           = st_ff.event_flag && pattern_alert_enable;
   assign alert_n                        = !status.pattern_alert;
endmodule

// File: inc/tgbpd_pkg.sv
// Package for the touch group blocking and pattern detect block
package tgbpd_pkg;
   localparam int          NUM_INPUTS          = 3;
   localparam logic [7:0]  ADDR_GROUP_CFG      = 8'h2A;
   localparam logic [7:0]  ADDR_PATTERN_CFG    = 8'h2B;
   localparam logic [7:0]  ADDR_PATTERN_SEL    = 8'h2D;
   localparam logic [7:0]  ADDR_BASE_RANGE     = 8'h2E;
   localparam logic [7:0]  RST_GROUP_CFG       = 8'h80;
   localparam logic [7:0]  RST_PATTERN_CFG     = 8'h00;
   localparam logic [7:0]  RST_PATTERN_SEL     = 8'h07;
   localparam int          POS_BLOCK_EN        = 7;
   localparam int          POS_LIMIT_LO        = 2;
   localparam int          POS_PAT_EN          = 7;
   localparam int          POS_PAT_TH_LO       = 2;
   localparam int          POS_PAT_MODE        = 1;
   localparam int          POS_PAT_ALERT       = 0;
   localparam logic [7:0]  MASK_GROUP_CFG      = 8'h8C;
   localparam logic [7:0]  MASK_PATTERN_CFG    = 8'h8F;
   localparam logic [7:0]  MASK_PATTERN_SEL    = 8'h07;

   // Per-input results of one sensing cycle
   typedef struct packed {
      logic [NUM_INPUTS-1:0] over_touch;
      logic [NUM_INPUTS-1:0] over_pattern;
      logic [NUM_INPUTS-1:0] noise;
      logic [NUM_INPUTS-1:0] base_fault;
   } tgbpd_sense_t;

   // Register access port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tgbpd_reg_req_t;

   // Flags toward the main status register and alert pin
   typedef struct packed {
      logic excess_touch_flag;
      logic pattern_event_flag;
      logic base_range_summary_flag;
      logic pattern_alert;
   } tgbpd_status_t;
endpackage

// File: logic/tgbpd_select.sv
// Picks the first limit touched inputs in sensing order
module tgbpd_select #(
   parameter int N = 3
) (
   input  wire logic [N-1:0] touched,
   input  wire logic [1:0]   limit,
   output logic      [N-1:0] chosen
);
   import tgbpd_pkg::*;

   initial begin
      if (N < 1 || N > 8) $error("tgbpd_select: N out of range");
   end

   logic [3:0] cnt [N+1];
   assign cnt[0] = 4'h0;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_sel
         assign chosen[i] = touched[i] && (cnt[i] < {2'h0, limit});
         assign cnt[i+1]  = cnt[i] + {3'h0, chosen[i]};
      end
   endgenerate
endmodule

// File: test/tgbpd_sva.sv
// Port checker for the touch group blocking block
module tgbpd_sva
   import tgbpd_pkg::*;
#(
   parameter int N = NUM_INPUTS
) (
   input wire logic                      clock,
   input wire logic                      rstn,
   input wire logic                      cycle_done,
   input wire tgbpd_pkg::tgbpd_sense_t   sense,
   input wire tgbpd_pkg::tgbpd_reg_req_t reg_req,
   input wire logic                      int_clear,
   input wire logic      [7:0]           reg_rdata,
   input wire logic      [1:0]           pattern_threshold_select,
   input wire logic      [N-1:0]         touch_report,
   input wire tgbpd_pkg::tgbpd_status_t  status,
   input wire logic                      alert_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_report_touched: assert property (cycle_done |=> (touch_report & ~$past(sense.over_touch)) == '0)
      else $error("report without touch");
   a_report_holds: assert property (!cycle_done |=> $stable(touch_report)) else $error("report moved");
   a_excess_cause: assert property (cycle_done && $countones(sense.over_touch) < 2 |=>
      !status.excess_touch_flag) else $error("excess without cause");
   a_event_sticky: assert property (status.pattern_event_flag && !int_clear |=>
      status.pattern_event_flag) else $error("event flag lost");
   a_alert_cause: assert property (!alert_n |-> status.pattern_event_flag) else $error("stray alert");
   a_base_summary: assert property (cycle_done |=>
      status.base_range_summary_flag == |$past(sense.base_fault)) else $error("summary wrong");
   a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
   a_base_reserved: assert property (reg_req.rd && reg_req.addr == ADDR_BASE_RANGE |=>
      reg_rdata[7:3] == 5'h00) else $error("reserved bits set");
   a_thresh_write: assert property (reg_req.wr && reg_req.addr == ADDR_PATTERN_CFG |=>
      pattern_threshold_select == $past(reg_req.wdata[3:2])) else $error("threshold select wrong");
   c_excess: cover property (status.excess_touch_flag);
   c_event: cover property ($rose(status.pattern_event_flag));
   c_alert: cover property (!alert_n);
endmodule
bind tgbpd_top tgbpd_sva #(.N(N)) u_sva (.clock, .rstn, .cycle_done, .sense, .reg_req, .int_clear,
   .reg_rdata, .pattern_threshold_select, .touch_report, .status, .alert_n);

// File: test/tgbpd_host.sv
// Host model driving register accesses and status clears
module tgbpd_host (
   input  wire logic                 clock,
   input  wire logic [7:0]           reg_rdata,
   output tgbpd_pkg::tgbpd_reg_req_t reg_req,
   output logic                      int_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   import tgbpd_pkg::*;
   initial {reg_req, int_clear} = '0;
   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      #10 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clock);
      #10 reg_req = '0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock);
      #10 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      #10 reg_req = '0;
      v = reg_rdata;
   endtask
   task clr;
      @(posedge clock);
      #10 int_clear = 1'b1;
      @(posedge clock);
      #10 int_clear = 1'b0;
   endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the touch group blocking block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tgbpd_pkg::*;
   logic           clock = 0, rstn = 0, cycle_done = 0, int_clear, alert_n;
   tgbpd_sense_t   sense = '0;
   tgbpd_reg_req_t reg_req;
   tgbpd_status_t  status;
   logic [7:0]     reg_rdata, obs, d;
   logic [1:0]     pattern_threshold_select;
   logic [2:0]     touch_report;
   logic [7:0]     adr[5] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E};
   logic [7:0]     rv[5] = '{8'h80, 8'h00, 8'h00, 8'h07, 8'h00};
   logic [7:0]     mv[5] = '{8'h8C, 8'h8F, 8'h00, 8'h07, 8'h00};
   int             miscompares = 0, cmp_count = 0, cyc = 0;
   always #50 clock = ~clock;
   // Flags, alert and report packed into one byte
   assign obs = {1'b0, status.excess_touch_flag, status.pattern_event_flag,
                 status.base_range_summary_flag, alert_n, touch_report};
   tgbpd_top DUT (.clock, .rstn, .cycle_done, .sense, .reg_req, .int_clear, .reg_rdata,
                  .pattern_threshold_select, .touch_report, .status, .alert_n);
   tgbpd_host host (.clock, .reg_rdata, .reg_req, .int_clear);
   task report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One nibble per field: touch, pattern, noise, base fault
   task sc(input logic [15:0] s, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      @(posedge clock);
      #10 cycle_done = 1'b1;
      sense = {s[14:12], s[10:8], s[6:4], s[2:0]};
      @(posedge clock);
      #10 cycle_done = 1'b0;
      chk(obs & m, e);
   endtask
   // Pattern event, refused clear, release, accepted clear
   task ev(input logic [15:0] s, input logic [7:0] e);
      sc(s, e);
      host.clr;
      chk(obs, e);
      sc(16'h1000, e | 8'h01);
      host.clr;
      chk(obs, 8'h09);
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         report_and_stop;
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      #10 rstn = 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 5; i++) begin
         host.rd(adr[i], d);
         chk(d, rv[i]);
         host.wr(adr[i], 8'hFF);
         host.rd(adr[i], d);
         chk(d, mv[i]);
      end
      host.wr(ADDR_PATTERN_CFG, 8'h00);
      for (int i = 0; i < 4; i++) begin
         host.wr(ADDR_GROUP_CFG, 8'h80 | 8'(i << 2));
         sc(16'h0000, 8'h08);
         sc(16'h7000, 8'h08 | (i == 0 ? 8'h41 : i == 1 ? 8'h43 : 8'h07));
      end
      host.wr(ADDR_GROUP_CFG, 8'h80);
      sc(16'h0000, 8'h08);
      sc(16'h6000, 8'h4A);
      sc(16'h3000, 8'h4A);
      sc(16'h1000, 8'h09);
      host.wr(ADDR_GROUP_CFG, 8'h00);
      sc(16'h7000, 8'h0F, 8'h3F);
      host.wr(ADDR_GROUP_CFG, 8'h80);
      host.wr(ADDR_PATTERN_SEL, 8'h03);
      host.wr(ADDR_PATTERN_CFG, 8'h83);
      sc(16'h1600, 8'h09);
      ev(16'h1300, 8'h20);
      ev(16'h1210, 8'h20);
      host.wr(ADDR_PATTERN_CFG, 8'h80);
      sc(16'h1400, 8'h09);
      ev(16'h1500, 8'h28);
      host.wr(ADDR_PATTERN_CFG, 8'h00);
      sc(16'h1700, 8'h09);
      for (int i = 0; i < 4; i++) begin
         host.wr(ADDR_PATTERN_CFG, 8'(i << 2));
         chk({6'h00, pattern_threshold_select}, 8'(i));
      end
      sc(16'h1005, 8'h19);
      host.rd(ADDR_BASE_RANGE, d);
      chk(d, 8'h05);
      report_and_stop;
   end
endmodule
